// *** rtl/alarm_ctrl_pkg.sv ***
// shared constants, register map and types for the alarm hysteresis and shutdown block
package alarm_ctrl_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int TEMP_W = 13;
	localparam int IRQ_W  = 3;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CONFIG    = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_TEMP      = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_UPPER     = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_LOWER     = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN    = 8'h18;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CFG_HYST_LO  = 9;
	localparam int CFG_HYST_HI  = 10;
	localparam int CFG_PDOWN    = 8;
	localparam int CFG_CRIT_LK  = 7;
	localparam int CFG_WIN_LK   = 6;
	localparam int TEMP_ABOVE   = 14;
	localparam int TEMP_BELOW   = 13;
	localparam int IRQ_ABOVE    = 0;
	localparam int IRQ_BELOW    = 1;
	localparam int IRQ_CONV     = 2;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [1:0]        RST_HYST  = 2'h0;
	localparam logic              RST_PDOWN = 1'b0;
	localparam logic              RST_LOCK  = 1'b0;
	localparam logic [TEMP_W-1:0] RST_UPPER = 13'h0000;
	localparam logic [TEMP_W-1:0] RST_LOWER = 13'h0000;
	localparam logic [TEMP_W-1:0] RST_TEMP  = 13'h0000;
	localparam logic [IRQ_W-1:0]  RST_IRQ   = 3'h0;

	// ----------------------------------------
	// hysteresis amounts in temperature lsb of 0.0625 degrees
	// ----------------------------------------
	localparam logic [1:0] HYST_OFF  = 2'h0;
	localparam logic [1:0] HYST_1P5  = 2'h1;
	localparam logic [1:0] HYST_3P0  = 2'h2;
	localparam logic [1:0] HYST_6P0  = 2'h3;
	localparam logic [TEMP_W-1:0] HYST_LSB_0   = 13'h0000;
	localparam logic [TEMP_W-1:0] HYST_LSB_1P5 = 13'h0018;
	localparam logic [TEMP_W-1:0] HYST_LSB_3P0 = 13'h0030;
	localparam logic [TEMP_W-1:0] HYST_LSB_6P0 = 13'h0060;

	// ----------------------------------------
	// bus request carried from the slave port to the register file
	// ----------------------------------------
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bus_req_t;

endpackage

// *** rtl/ahb_reg_port.sv ***
// ahb-lite slave port turning transfers into register strobes
`timescale 1ns/1ns
module ahb_reg_port (
	input  wire logic                         sys_clk,
	input  wire logic                         rst,
	input  wire logic                         hsel,
	input  wire logic [31:0]                  haddr,
	input  wire logic [1:0]                   htrans,
	input  wire logic                         hwrite,
	input  wire logic [2:0]                   hsize,
	input  wire logic                         hready,
	input  wire logic [31:0]                  hwdata,
	input  wire logic [31:0]                  rd_data,
	output logic                              hreadyout,
	output logic                              hresp,
	output logic [31:0]                       hrdata,
	output alarm_ctrl_pkg::bus_req_t          req
);
	import alarm_ctrl_pkg::*;

	logic              wr_pend;
	logic              rd_pend;
	logic [ADDR_W-1:0] addr_q;
	logic              take;

	// only whole-word transfers are expected; hsize is not checked
	assign take = hsel & htrans[1] & hready;

	// ----------------------------------------
	// address phase capture
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			addr_q  <= '0;
		end else begin
			wr_pend <= take & hwrite;
			rd_pend <= take & ~hwrite;
			if (take) begin
				addr_q <= haddr[ADDR_W-1:0];
			end
		end
	end

	// one wait state on reads so a write just before is already visible
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= '0;
		end else begin
			hreadyout <= ~(take & ~hwrite);
			hresp     <= 1'b0;
			if (rd_pend) begin
				hrdata <= rd_data;
			end
		end
	end

	assign req.wr    = wr_pend;
	assign req.rd    = rd_pend;
	assign req.addr  = addr_q;
	assign req.wdata = hwdata;

endmodule

// *** rtl/window_hysteresis.sv ***
// above and below window flags with hysteresis
`timescale 1ns/1ns
module window_hysteresis #(
	parameter int TW = 13
) (
	input  wire logic          sys_clk,
	input  wire logic          rst,
	input  wire logic          eval,
	input  wire logic [TW-1:0] temp,
	input  wire logic [TW-1:0] upper,
	input  wire logic [TW-1:0] lower,
	input  wire logic [TW-1:0] hyst,
	output logic               above,
	output logic               below
);
	// one extra bit so boundary minus hysteresis never wraps
	logic signed [TW:0] t_s;
	logic signed [TW:0] up_s;
	logic signed [TW:0] lo_s;
	logic signed [TW:0] up_rel;
	logic signed [TW:0] lo_rel;

	assign t_s    = {temp[TW-1], temp};
	assign up_s   = {upper[TW-1], upper};
	assign lo_s   = {lower[TW-1], lower};
	assign up_rel = up_s - $signed({1'b0, hyst});
	assign lo_rel = lo_s - $signed({1'b0, hyst});

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			above <= 1'b0;
		end else if (eval) begin // R13
			if (!above) begin
				above <= t_s > up_s; // R3
			end else begin
				above <= ~(t_s <= up_rel); // R4
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			below <= 1'b0;
		end else if (eval) begin // R13
			if (below) begin
				below <= ~(t_s >= lo_s); // R5
			end else begin
				below <= t_s <= lo_rel; // R6
			end
		end
	end

endmodule

// *** rtl/alarm_hysteresis_shutdown_ctrl.sv ***
// alarm window hysteresis, shutdown control and lock bits behind an ahb-lite port
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns

//
// Contract
// R1: hysteresis select resets to 00 (off); 01 selects 1.5 degrees.
// R2: select 10 gives 3 degrees, 11 gives 6 degrees.
// R3: above flag (bit 14) sets when temperature strictly exceeds upper boundary.
// R4: set above flag clears only at or below upper boundary minus hysteresis.
// R5: below flag (bit 13) clears when temperature reaches lower boundary or more.
// R6: below flag sets only at or below lower boundary minus hysteresis.
// R7: alert pin asserts and releases with the same hysteresis as flags.
// R8: hysteresis select writes ignored while either lock bit is set.
// R9: power-down bit resets to 0 (running); writing 1 enters shutdown.
// R10: in shutdown front end and converter off, no alarm events.
// R11: locks block setting power-down but clearing is always accepted.
// R12: lock bits set by one write, read 1, cleared only by reset.
// R13: flags are re-evaluated whenever a new conversion result is latched.
module alarm_hysteresis_shutdown_ctrl (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        conv_valid,
	input  wire logic [12:0] conv_temp,
	output logic             front_end_enable,
	output logic             alert_out,
	output logic             irq
);
	import alarm_ctrl_pkg::*;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	bus_req_t          req;
	logic [DATA_W-1:0] rd_data;
	logic [1:0]        hysteresis_select;
	logic              sensor_power_down;
	logic              critical_limit_lock;
	logic              alarm_window_lock;
	logic              any_lock;
	logic [TEMP_W-1:0] temp_value;
	logic [TEMP_W-1:0] upper_bound;
	logic [TEMP_W-1:0] lower_bound;
	logic [TEMP_W-1:0] hyst_amount;
	logic              above_flag;
	logic              below_flag;
	logic              above_prev;
	logic              below_prev;
	logic              latch_conv;
	logic              conv_seen;
	logic [IRQ_W-1:0]  irq_status;
	logic [IRQ_W-1:0]  irq_enable;
	logic [IRQ_W-1:0]  irq_set;
	logic [IRQ_W-1:0]  irq_clr;
	logic              wr_config;
	logic              wr_upper;
	logic              wr_lower;
	logic              wr_irq_clear;
	logic              wr_irq_en;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [TEMP_W-1:0] hyst_lsb(input logic [1:0] sel);
		logic [TEMP_W-1:0] v;
		v = HYST_LSB_0;
		unique case (sel)
			HYST_OFF: v = HYST_LSB_0;   // R1
			HYST_1P5: v = HYST_LSB_1P5; // R1
			HYST_3P0: v = HYST_LSB_3P0; // R2
			HYST_6P0: v = HYST_LSB_6P0; // R2
		endcase
		return v;
	endfunction

	function automatic logic hit(input bus_req_t r, input logic [ADDR_W-1:0] ofs);
		return r.wr & (r.addr == ofs);
	endfunction

	// ----------------------------------------
	// bus port
	// ----------------------------------------
	ahb_reg_port u_port (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hready    (hready),
		.hwdata    (hwdata),
		.rd_data   (rd_data),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.req       (req)
	);

	// ----------------------------------------
	// write strobes
	// ----------------------------------------
	assign wr_config    = hit(req, OFS_CONFIG);
	assign wr_upper     = hit(req, OFS_UPPER);
	assign wr_lower     = hit(req, OFS_LOWER);
	assign wr_irq_clear = hit(req, OFS_IRQ_CLEAR);
	assign wr_irq_en    = hit(req, OFS_IRQ_EN);
	assign any_lock     = critical_limit_lock | alarm_window_lock;

	// ----------------------------------------
	// lock bits
	// ----------------------------------------
	// a write of 0 never clears them; only reset does
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			critical_limit_lock <= RST_LOCK;
		end else if (wr_config) begin
			critical_limit_lock <= critical_limit_lock | req.wdata[CFG_CRIT_LK]; // R12
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			alarm_window_lock <= RST_LOCK;
		end else if (wr_config) begin
			alarm_window_lock <= alarm_window_lock | req.wdata[CFG_WIN_LK]; // R12
		end
	end

	// ----------------------------------------
	// hysteresis select
	// ----------------------------------------
	// lock state before the write decides, so a write setting a lock still updates
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hysteresis_select <= RST_HYST; // R1
		end else if (wr_config && !any_lock) begin // R8
			hysteresis_select <= req.wdata[CFG_HYST_HI:CFG_HYST_LO];
		end
	end

	assign hyst_amount = hyst_lsb(hysteresis_select);

	// ----------------------------------------
	// shutdown control
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sensor_power_down <= RST_PDOWN; // R9
		end else if (wr_config) begin
			// clearing is never blocked, so a locked part can always be woken
			if (!req.wdata[CFG_PDOWN]) begin
				sensor_power_down <= 1'b0; // R11
			end else if (!any_lock) begin // R11
				sensor_power_down <= 1'b1; // R9
			end
		end
	end

	// front end power follows the bit; the converter stops delivering results
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			front_end_enable <= 1'b1;
		end else begin
			front_end_enable <= ~sensor_power_down; // R10
		end
	end

	// ----------------------------------------
	// alarm window boundaries
	// ----------------------------------------
	// the window lock guards both boundaries
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			upper_bound <= RST_UPPER;
		end else if (wr_upper && !alarm_window_lock) begin
			upper_bound <= req.wdata[TEMP_W-1:0];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lower_bound <= RST_LOWER;
		end else if (wr_lower && !alarm_window_lock) begin
			lower_bound <= req.wdata[TEMP_W-1:0];
		end
	end

	// ----------------------------------------
	// conversion results
	// ----------------------------------------
	// results arriving in shutdown are dropped, which also freezes the flags
	assign latch_conv = conv_valid & ~sensor_power_down; // R10

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			temp_value <= RST_TEMP;
		end else if (latch_conv) begin
			temp_value <= conv_temp;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			conv_seen <= 1'b0;
		end else begin
			conv_seen <= latch_conv;
		end
	end

	// flags read conv_temp so they agree with the value latched on the same edge
	window_hysteresis #(
		.TW (TEMP_W)
	) u_window (
		.sys_clk (sys_clk),
		.rst     (rst),
		.eval    (latch_conv),
		.temp    (conv_temp),
		.upper   (upper_bound),
		.lower   (lower_bound),
		.hyst    (hyst_amount),
		.above   (above_flag),
		.below   (below_flag)
	);

	// ----------------------------------------
	// alert pin
	// ----------------------------------------
	// driven from the hysteresis flags, so release follows the same threshold
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			alert_out <= 1'b0;
		end else begin
			alert_out <= above_flag | below_flag; // R7
		end
	end

	// ----------------------------------------
	// interrupt events
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			above_prev <= 1'b0;
		end else begin
			above_prev <= above_flag;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			below_prev <= 1'b0;
		end else begin
			below_prev <= below_flag;
		end
	end

	// flags only move on a latched conversion, so shutdown raises nothing
	always_comb begin
		irq_set            = '0;
		irq_set[IRQ_ABOVE] = above_flag & ~above_prev; // R10
		irq_set[IRQ_BELOW] = below_flag & ~below_prev; // R10
		irq_set[IRQ_CONV]  = conv_seen;
	end

	assign irq_clr = wr_irq_clear ? req.wdata[IRQ_W-1:0] : '0;

	// ----------------------------------------
	// sticky status bits
	// ----------------------------------------
	// a new event in the clearing cycle survives the clear
	for (genvar b = 0; b < IRQ_W; b++) begin : g_status
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				irq_status[b] <= RST_IRQ[b];
			end else if (irq_set[b]) begin
				irq_status[b] <= 1'b1;
			end else if (irq_clr[b]) begin
				irq_status[b] <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// interrupt enable and pin
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_enable <= RST_IRQ;
		end else if (wr_irq_en) begin
			irq_enable <= req.wdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_enable);
		end
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	// unmapped and write-only offsets read as zero
	always_comb begin
		rd_data = '0;
		unique case (req.addr)
			OFS_CONFIG: begin
				rd_data[CFG_HYST_HI:CFG_HYST_LO] = hysteresis_select;
				rd_data[CFG_PDOWN]                = sensor_power_down;
				rd_data[CFG_CRIT_LK]              = critical_limit_lock; // R12
				rd_data[CFG_WIN_LK]               = alarm_window_lock;   // R12
			end
			OFS_TEMP: begin
				rd_data[TEMP_W-1:0] = temp_value;
				rd_data[TEMP_ABOVE] = above_flag; // R3
				rd_data[TEMP_BELOW] = below_flag; // R5
			end
			OFS_UPPER: begin
				rd_data[TEMP_W-1:0] = upper_bound;
			end
			OFS_LOWER: begin
				rd_data[TEMP_W-1:0] = lower_bound;
			end
			OFS_IRQ_STAT: begin
				rd_data[IRQ_W-1:0] = irq_status;
			end
			OFS_IRQ_EN: begin
				rd_data[IRQ_W-1:0] = irq_enable;
			end
			default: begin
				rd_data = '0;
			end
		endcase
	end

endmodule

// *** dv/alarm_hysteresis_shutdown_ctrl_chk.sv ***
// port-level assertions for the alarm hysteresis and shutdown block
`timescale 1ns/1ns
module alarm_hysteresis_shutdown_ctrl_chk (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        conv_valid,
	input wire logic [12:0] conv_temp,
	input wire logic        front_end_enable,
	input wire logic        alert_out,
	input wire logic        irq
);
	import alarm_ctrl_pkg::*;
	logic taken;
	logic cfg_wr;
	assign taken = hsel & htrans[1] & hready;
	assign cfg_wr = taken & hwrite & (haddr[7:0] == OFS_CONFIG);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read data phase not one wait cycle");
	chk_write_nowait: assert property (taken && hwrite |=> hreadyout)
		else $error("write data phase stalled");
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	chk_reset_state: assert property ($past(rst) |-> front_end_enable && !alert_out && !irq)
		else $error("outputs wrong after reset");
	// a dropped conversion leaves the flags, hence the alert, untouched
	chk_pdown_freeze: assert property (conv_valid ##1 !front_end_enable |=> $stable(alert_out))
		else $error("alert moved on a conversion in shutdown");
	chk_alert_cause: assert property ($changed(alert_out) |-> $past(conv_valid, 2))
		else $error("alert changed without a conversion");
	chk_irq_cause: assert property ($rose(irq) |-> $past(conv_valid, 3) || $past(taken, 3)
		|| $past(taken, 2))
		else $error("interrupt rose without a cause");
	chk_fe_drop: assert property ($fell(front_end_enable)
		|-> $past(cfg_wr, 3) && $past(hwdata[CFG_PDOWN], 2))
		else $error("front end dropped without a shutdown write");
	chk_fe_rise: assert property ($rose(front_end_enable)
		|-> $past(cfg_wr, 3) && !$past(hwdata[CFG_PDOWN], 2))
		else $error("front end rose without a clearing write");
endmodule

bind alarm_hysteresis_shutdown_ctrl alarm_hysteresis_shutdown_ctrl_chk u_chk (
	.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .conv_valid(conv_valid), .conv_temp(conv_temp),
	.front_end_enable(front_end_enable), .alert_out(alert_out), .irq(irq)
);

// *** dv/alarm_hysteresis_shutdown_ctrl_test.sv ***
// self-checking bench for the alarm hysteresis and shutdown block
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin fails++; \
	$display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module alarm_hysteresis_shutdown_ctrl_test;
	import alarm_ctrl_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        conv_valid = 1'b0;
	logic [12:0] conv_temp = 13'h0;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        front_end_enable;
	logic        alert_out;
	logic        irq;
	logic [31:0] rd;
	int          fails = 0;
	int          compares = 0;

	initial forever #5 sys_clk = ~sys_clk;

	alarm_hysteresis_shutdown_ctrl u_dut (
		.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .conv_valid(conv_valid),
		.conv_temp(conv_temp), .front_end_enable(front_end_enable), .alert_out(alert_out),
		.irq(irq)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic test_done();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic do_reset();
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
	endtask

	// bounded wait: a hung slave ends the run instead of the bench
	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 20) begin
				fails++;
				test_done();
			end
			@(posedge sys_clk);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
		hsel <= 1'b0;
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(1'b0, a, 32'h0);
		`CHK(nm, e, rd)
	endtask

	// three edges after the pulse let flags, alert and irq all land
	task automatic conv(input logic [12:0] t);
		@(posedge sys_clk);
		conv_valid <= 1'b1;
		conv_temp <= t;
		@(posedge sys_clk);
		conv_valid <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic conv_chk(input logic [12:0] t, input logic ab, input logic bl);
		conv(t);
		`CHK("alert", ab | bl, alert_out)
		chk_rd(OFS_TEMP, {17'h0, ab, bl, t}, "temp");
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		`CHK("fe_reset", 1'b1, front_end_enable)
		chk_rd(OFS_CONFIG, 32'h0, "config_reset");
		chk_rd(8'h40, 32'h0, "unmapped");
		$display("test reset done");
	endtask

	task automatic t_hyst();
		logic [12:0] h [4];
		h = '{13'h0000, 13'h0018, 13'h0030, 13'h0060};
		bus(1'b1, OFS_UPPER, 32'h100);
		bus(1'b1, OFS_LOWER, 32'h0a0);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, OFS_CONFIG, 32'(i) << 9);
			chk_rd(OFS_CONFIG, 32'(i) << 9, "hyst_sel");
			conv_chk(13'h100, 1'b0, 1'b0);
			conv_chk(13'h101, 1'b1, 1'b0);
			conv_chk(13'h101 - h[i], 1'b1, 1'b0);
			conv_chk(13'h100 - h[i], 1'b0, 1'b0);
			conv_chk(13'h09f, 1'b0, h[i] == 13'h0);
			conv_chk(13'h0a0 - h[i], 1'b0, h[i] != 13'h0);
			conv_chk((h[i] == 13'h0) ? 13'h0a1 : 13'h0a0, 1'b0, 1'b0);
		end
		$display("test hysteresis done");
	endtask

	task automatic t_pdown_irq();
		bus(1'b1, OFS_IRQ_CLEAR, 32'h7);
		bus(1'b1, OFS_IRQ_EN, 32'h7);
		chk_rd(OFS_IRQ_STAT, 32'h0, "irq_cleared");
		`CHK("irq_idle", 1'b0, irq)
		bus(1'b1, OFS_CONFIG, 32'h100);
		chk_rd(OFS_CONFIG, 32'h100, "pdown_set");
		`CHK("fe_off", 1'b0, front_end_enable)
		conv(13'h200);
		chk_rd(OFS_TEMP, 32'h0a0, "temp_frozen");
		chk_rd(OFS_IRQ_STAT, 32'h0, "no_event");
		`CHK("alert_frozen", 1'b0, alert_out)
		bus(1'b1, OFS_CONFIG, 32'h0);
		conv_chk(13'h200, 1'b1, 1'b0);
		`CHK("fe_on", 1'b1, front_end_enable)
		chk_rd(OFS_IRQ_STAT, 32'h5, "irq_stat");
		`CHK("irq_on", 1'b1, irq)
		bus(1'b1, OFS_IRQ_EN, 32'h0);
		bus(1'b1, OFS_IRQ_CLEAR, 32'h7);
		chk_rd(OFS_IRQ_STAT, 32'h0, "irq_clr");
		`CHK("irq_off", 1'b0, irq)
		$display("test shutdown and interrupt done");
	endtask

	task automatic t_lock();
		bus(1'b1, OFS_CONFIG, 32'h100);
		bus(1'b1, OFS_CONFIG, 32'h340);
		chk_rd(OFS_CONFIG, 32'h340, "lock_set");
		bus(1'b1, OFS_CONFIG, 32'h600);
		chk_rd(OFS_CONFIG, 32'h240, "locked_clear");
		bus(1'b1, OFS_CONFIG, 32'h100);
		chk_rd(OFS_CONFIG, 32'h240, "locked_set");
		`CHK("fe_locked", 1'b1, front_end_enable)
		do_reset();
		chk_rd(OFS_CONFIG, 32'h0, "lock_reset");
		bus(1'b1, OFS_CONFIG, 32'h080);
		bus(1'b1, OFS_CONFIG, 32'h780);
		chk_rd(OFS_CONFIG, 32'h080, "crit_locked");
		$display("test locks done");
	endtask

	initial begin
		do_reset();
		t_reset();
		t_hyst();
		t_pdown_irq();
		t_lock();
		test_done();
	end
endmodule
